// [core/timer_compare_regs.vh]
// Purpose: Register map, fields and constants of the 10-bit compare timer
// Assumes: AXI4-Lite byte addresses, one 32-bit word per register
// Notes:   Register index times four gives the byte address
// Function
// - Mode field: 00 compare, 01 capture, 10 PWM/pulse, 11 timer.
// - Compare mode A match: keep, drive low, drive high, or toggle output.
// - PWM mode pin field: inactive, active, PWM waveform, or single pulse.
// - Capture mode: rising, falling, both edges, or capture disabled.
// - Requested match level equal to initial level shows no pin change.
// - Counter-on rising edge returns compare output to its initial level.
// - Level bit: initial level in compare, active level in PWM/pulse.
// - Polarity bit inverts the output pin; no effect in capture or timer mode.
// - Swap bit selects which compare value sets period and which duty.
// - Clear select: A match, else P match or overflow when P zero.
// - Clear select ignored in PWM, single pulse and capture modes.
// - Counter reads as 10 bits split low byte and two high bits.
// - Compare-A is a read/write 10-bit pair, reset zero.
// - Clear select 0 raises both A and P flags on their matches.
// - Clear select 1 raises only the A flag, never the P flag.
// - Compare-A zero overflows at 3FF without raising the A flag.
// - In compare mode, of the A and P match events only A match changes the pin.
// - Timer/counter mode drives the pin low and leaves pin field unused.
// - Counter-on rise clears counter; fall stops and keeps value.
// - Pause high holds the counter; low resumes from held value.
// - Compare-P matches counter bits 9..7; zero means 1024 clocks.
`ifndef TIMER_COMPARE_REGS_VH
`define TIMER_COMPARE_REGS_VH
`define OFS_TIMER_CONTROL   6'h00
`define OFS_MODE_CONTROL    6'h04
`define OFS_COUNT_LOW       6'h08
`define OFS_COUNT_HIGH      6'h0C
`define OFS_COMPARE_A_LOW   6'h10
`define OFS_COMPARE_A_HIGH  6'h14
`define OFS_FLAGS           6'h18
`define CTL_PAUSE_BIT       7
`define CTL_ON_BIT          3
`define MODE_COMPARE        2'b00
`define MODE_CAPTURE        2'b01
`define MODE_PWM            2'b10
`define MODE_TIMER          2'b11
`define PIN_00              2'b00
`define PIN_01              2'b01
`define PIN_10              2'b10
`define PIN_11              2'b11
`define COUNT_MAX           10'h3FF
`define RESET_BYTE          8'h00
`define RESP_OKAY           2'b00
`define RESP_SLVERR         2'b10
`endif

// [core/timer_compare.v]
// Purpose: 10-bit standard timer with compare, capture, PWM and pulse modes
// Assumes: AXI4-Lite slave, timer clock is aclk gated by clk_en
// Notes:   clk_en low freezes all state including the bus slave
`timescale 1ns/10ps
`include "timer_compare_regs.vh"
module timer_compare (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire        clk_en,
    input  wire [5:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [5:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        capture_input_pin,
    output reg         timer_out_pin,
    output reg         match_a_flag,
    output reg         match_p_flag
);

reg  [7:0] timer_control_q;
reg  [7:0] mode_control_q;
reg  [9:0] count_q;
reg  [9:0] compare_a_value_q;
reg  [7:0] compare_a_buf_q;
reg        on_prev_q;
reg        cap_prev_q;
reg        level_q;
reg        pwm_q;
reg        aw_hold_q;
reg        w_hold_q;
reg  [5:0] aw_addr_q;
reg [31:0] w_data_q;
reg        w_lane0_q;

function sel_is_reg;
    input [5:0] a;
    begin
        sel_is_reg = (a[1:0] == 2'b00) && (a <= `OFS_FLAGS);
    end
endfunction

// ----------------------------------------------------------------------
// Field decode
// ----------------------------------------------------------------------
wire [1:0] mode_sel      = mode_control_q[7:6];
wire [1:0] pin_function  = mode_control_q[5:4];
wire       level_ctl     = mode_control_q[3];
wire       output_invert = mode_control_q[2];
wire       duty_swap     = mode_control_q[1];
wire       clear_source  = mode_control_q[0];
wire       counter_on    = timer_control_q[`CTL_ON_BIT];
wire       counter_pause = timer_control_q[`CTL_PAUSE_BIT];
wire [2:0] compare_p_value = timer_control_q[2:0];

wire on_rise  = counter_on & ~on_prev_q;
wire running  = counter_on & ~counter_pause & ~on_rise;
wire is_pwm   = (mode_sel == `MODE_PWM);
wire is_pulse = is_pwm && (pin_function == `PIN_11);
wire is_cap   = (mode_sel == `MODE_CAPTURE);

// Comparators sample the present count
wire match_a = running && (count_q == compare_a_value_q)
               && (compare_a_value_q != 10'h000);
wire match_p = running && (compare_p_value != 3'b000)
               && (count_q[9:7] == compare_p_value)
               && (count_q[6:0] == 7'h00);
wire overflow = running && (count_q == `COUNT_MAX);

// Clear source per mode
reg clear_now;
always @* begin
    clear_now = 1'b0;
    if (is_pwm && !is_pulse) begin
        clear_now = duty_swap ? match_a : (match_p ||
                    (compare_p_value == 3'b000 && overflow));
    end else if (is_cap) begin
        clear_now = match_p || (compare_p_value == 3'b000 && overflow);
    end else if (!is_pwm) begin
        if (clear_source)
            clear_now = match_a;
        else
            clear_now = match_p || (compare_p_value == 3'b000 && overflow);
    end
end

wire flag_p_evt = match_p && !(clear_source && !is_pwm && !is_cap);
wire cap_edge   = (pin_function == `PIN_00) ? (capture_input_pin & ~cap_prev_q)
                : (pin_function == `PIN_01) ? (~capture_input_pin & cap_prev_q)
                : (pin_function == `PIN_10) ? (capture_input_pin ^ cap_prev_q)
                : 1'b0;
wire do_capture = is_cap && counter_on && cap_edge;

// ----------------------------------------------------------------------
// Bus write decode
// ----------------------------------------------------------------------
wire aw_ok   = aw_hold_q || s_axi_awvalid;
wire w_ok    = w_hold_q || s_axi_wvalid;
wire [5:0]  wr_addr = aw_hold_q ? aw_addr_q : s_axi_awaddr;
wire [31:0] wr_data = w_hold_q ? w_data_q : s_axi_wdata;
wire        wr_lane = w_hold_q ? w_lane0_q : s_axi_wstrb[0];
wire wr_fire = aw_ok && w_ok && !s_axi_bvalid;
wire wr_en   = wr_fire && wr_lane && sel_is_reg(wr_addr);
wire wr_tc   = wr_en && wr_addr == `OFS_TIMER_CONTROL;
wire wr_mc   = wr_en && wr_addr == `OFS_MODE_CONTROL;
wire wr_al   = wr_en && wr_addr == `OFS_COMPARE_A_LOW;
wire wr_ah   = wr_en && wr_addr == `OFS_COMPARE_A_HIGH;
wire wr_fl   = wr_en && wr_addr == `OFS_FLAGS;

// ----------------------------------------------------------------------
// Counter, compare, capture and flags
// ----------------------------------------------------------------------
always @(posedge aclk) begin
    if (!aresetn) begin
        timer_control_q   <= `RESET_BYTE;
        mode_control_q    <= `RESET_BYTE;
        count_q           <= 10'h000;
        compare_a_value_q <= 10'h000;
        compare_a_buf_q   <= `RESET_BYTE;
        on_prev_q         <= 1'b0;
        cap_prev_q        <= 1'b0;
        match_a_flag      <= 1'b0;
        match_p_flag      <= 1'b0;
    end else if (clk_en) begin
        on_prev_q  <= counter_on;
        cap_prev_q <= capture_input_pin;
        if (on_rise)
            count_q <= 10'h000;
        else if (running)
            count_q <= clear_now ? 10'h000 : count_q + 10'h001;
        mode_control_q <= wr_mc ? wr_data[7:0] : mode_control_q;
        // Pulse ends on A match by clearing counter-on
        if (wr_tc)
            timer_control_q <= wr_data[7:0];
        else if (is_pulse && match_a)
            timer_control_q[`CTL_ON_BIT] <= 1'b0;
        if (wr_al)
            compare_a_buf_q <= wr_data[7:0];
        if (do_capture)
            compare_a_value_q <= count_q;
        else if (wr_ah)
            compare_a_value_q <= {wr_data[1:0], compare_a_buf_q};
        // Set wins over software clear
        if (match_a)
            match_a_flag <= 1'b1;
        else if (do_capture)
            match_a_flag <= 1'b1;
        else if (wr_fl && wr_data[0])
            match_a_flag <= 1'b0;
        if (flag_p_evt && !is_pulse)
            match_p_flag <= 1'b1;
        else if (wr_fl && wr_data[1])
            match_p_flag <= 1'b0;
    end
end

// ----------------------------------------------------------------------
// Output pin
// ----------------------------------------------------------------------
wire duty_hit = duty_swap ? match_p : match_a;
always @(posedge aclk) begin
    if (!aresetn) begin
        level_q       <= 1'b0;
        pwm_q         <= 1'b0;
        timer_out_pin <= 1'b0;
    end else if (clk_en) begin
        if (mode_sel == `MODE_COMPARE) begin
            if (on_rise)
                level_q <= level_ctl;
            else if (match_a) begin
                case (pin_function)
                    `PIN_01: level_q <= 1'b0;
                    `PIN_10: level_q <= 1'b1;
                    `PIN_11: level_q <= ~level_q;
                    default: level_q <= level_q;
                endcase
            end
        end
        // PWM active from period start until duty match
        if (on_rise || (running && clear_now))
            pwm_q <= 1'b1;
        else if (duty_hit)
            pwm_q <= 1'b0;
        case (mode_sel)
            `MODE_COMPARE: timer_out_pin <= level_q ^ output_invert;
            `MODE_PWM: begin
                case (pin_function)
                    `PIN_00: timer_out_pin <= ~level_ctl ^ output_invert;
                    `PIN_01: timer_out_pin <= level_ctl ^ output_invert;
                    `PIN_10: timer_out_pin <= (pwm_q ? level_ctl : ~level_ctl)
                                              ^ output_invert;
                    default: timer_out_pin <= (counter_on ? level_ctl
                                              : ~level_ctl) ^ output_invert;
                endcase
            end
            default: timer_out_pin <= 1'b0;
        endcase
    end
end

// ----------------------------------------------------------------------
// AXI4-Lite slave
// ----------------------------------------------------------------------
reg [31:0] rd_word;
always @* begin
    rd_word = 32'h0000_0000;
    case (s_axi_araddr)
        `OFS_TIMER_CONTROL:  rd_word = {24'h00_0000, timer_control_q};
        `OFS_MODE_CONTROL:   rd_word = {24'h00_0000, mode_control_q};
        `OFS_COUNT_LOW:      rd_word = {24'h00_0000, count_q[7:0]};
        `OFS_COUNT_HIGH:     rd_word = {30'h0000_0000, count_q[9:8]};
        `OFS_COMPARE_A_LOW:  rd_word = {24'h00_0000, compare_a_value_q[7:0]};
        `OFS_COMPARE_A_HIGH: rd_word = {30'h0000_0000, compare_a_value_q[9:8]};
        `OFS_FLAGS:          rd_word = {30'h0000_0000, match_p_flag,
                                        match_a_flag};
        default:             rd_word = 32'h0000_0000;
    endcase
end

always @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_awready <= 1'b0;
        s_axi_wready  <= 1'b0;
        s_axi_bvalid  <= 1'b0;
        s_axi_bresp   <= `RESP_OKAY;
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b0;
        s_axi_rresp   <= `RESP_OKAY;
        s_axi_rdata   <= 32'h0000_0000;
        aw_hold_q     <= 1'b0;
        w_hold_q      <= 1'b0;
        aw_addr_q     <= 6'h00;
        w_data_q      <= 32'h0000_0000;
        w_lane0_q     <= 1'b0;
    end else if (clk_en) begin
        s_axi_awready <= 1'b0;
        s_axi_wready  <= 1'b0;
        s_axi_arready <= 1'b0;
        if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
        if (wr_fire) begin
            s_axi_awready <= !aw_hold_q;
            s_axi_wready  <= !w_hold_q;
            aw_hold_q     <= 1'b0;
            w_hold_q      <= 1'b0;
            s_axi_bvalid  <= 1'b1;
            s_axi_bresp   <= sel_is_reg(wr_addr) ? `RESP_OKAY : `RESP_SLVERR;
        end else begin
            if (s_axi_awvalid && !aw_hold_q && !s_axi_awready) begin
                s_axi_awready <= 1'b1;
                aw_hold_q     <= 1'b1;
                aw_addr_q     <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_hold_q && !s_axi_wready) begin
                s_axi_wready <= 1'b1;
                w_hold_q     <= 1'b1;
                w_data_q     <= s_axi_wdata;
                w_lane0_q    <= s_axi_wstrb[0];
            end
        end
        if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
        else if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_word;
            s_axi_rresp   <= sel_is_reg(s_axi_araddr) ? `RESP_OKAY
                                                      : `RESP_SLVERR;
        end
    end
end

endmodule

// [tb/timer_compare_checker.sv]
// Purpose: Port checks for timer_compare
// Assumes: Bound to every timer_compare instance
// Notes:   Bus handshakes, clock-enable freeze, flag clearing
`timescale 1ns/10ps
module timer_compare_checker (
    input logic aclk,
    input logic aresetn,
    input logic clk_en,
    input logic s_axi_awvalid,
    input logic s_axi_wvalid,
    input logic s_axi_bvalid,
    input logic s_axi_bready,
    input logic s_axi_arvalid,
    input logic s_axi_arready,
    input logic s_axi_rvalid,
    input logic s_axi_rready,
    input logic timer_out_pin,
    input logic match_a_flag,
    input logic match_p_flag
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    chk_bvalid_hold:
        assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("Write response dropped early");
    chk_rvalid_hold:
        assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("Read data dropped early");
    chk_b_release:
        assert property (s_axi_bvalid && s_axi_bready && clk_en
            |=> !s_axi_bvalid)
        else $error("Write response held after handshake");
    chk_ar_answer:
        assert property (s_axi_arready |-> s_axi_rvalid)
        else $error("Read accept without data");
    chk_ar_pulse:
        assert property (s_axi_arready && clk_en |=> !s_axi_arready)
        else $error("Read accept longer than one cycle");
    chk_b_cause:
        assert property ($rose(s_axi_bvalid)
            |-> $past(s_axi_awvalid || s_axi_wvalid))
        else $error("Write response without request");
    chk_r_cause:
        assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid))
        else $error("Read data without request");
    chk_freeze_hold:
        assert property (!clk_en |=> $stable({timer_out_pin,
            match_a_flag, match_p_flag, s_axi_bvalid, s_axi_rvalid}))
        else $error("State moved while clock enable low");
    chk_flag_clear:
        assert property ($past(aresetn) && ($fell(match_a_flag)
            || $fell(match_p_flag)) |-> $rose(s_axi_bvalid))
        else $error("Flag cleared without a write");
endmodule
bind timer_compare timer_compare_checker u_chk (.aclk, .aresetn, .clk_en,
    .s_axi_awvalid, .s_axi_wvalid, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
    .timer_out_pin, .match_a_flag, .match_p_flag);

// [tb/tb_top.sv]
// Purpose: Self-checking bench for timer_compare
// Assumes: AXI4-Lite master tasks, fixed random seed
// Notes:   Compare-match output, flags, counter and register map
`timescale 1ns/10ps
`include "timer_compare_regs.vh"
module tb_top;
    logic        aclk, aresetn, clk_en, awvalid, wvalid, bready, arvalid;
    logic        rready, cap, awready, wready, bvalid, arready, rvalid;
    logic        pin, fa, fp, oc, pol;
    logic [5:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, d, v, lo;
    logic [1:0]  bresp, rresp, r;
    int          err_count, samples_checked, n, k;

    timer_compare DUT (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .capture_input_pin(cap),
        .timer_out_pin(pin), .match_a_flag(fa), .match_p_flag(fp));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    always #5 aclk = ~aclk;
    always @(posedge aclk) cap <= ^$urandom;

    task automatic check(input string nm, input logic [31:0] s, e);
        samples_checked++;
        if (s !== e) begin
            err_count++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic test_done;
        $display("Compared %0d, mismatched %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic hang(input string nm);
        err_count++;
        $display("BAD %s expected done seen timeout", nm);
        test_done();
    endtask
    task automatic wr(input [5:0] a, input [31:0] dt);
        bit b;
        int i;
        @(posedge aclk);
        awaddr <= a; wdata <= dt; awvalid <= 1; wvalid <= 1; bready <= 1;
        b = 1;
        for (i = 0; b && i < 50; i++) begin
            @(posedge aclk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
            if (bvalid) begin
                bready <= 0; b = 0; r = bresp;
            end
        end
        if (b) hang("write");
    endtask
    task automatic rd(input [5:0] a);
        bit b;
        int i;
        @(posedge aclk);
        araddr <= a; arvalid <= 1; rready <= 1;
        b = 1;
        for (i = 0; b && i < 50; i++) begin
            @(posedge aclk);
            if (arready) arvalid <= 0;
            if (rvalid) begin
                rready <= 0; b = 0; d = rdata; r = rresp;
            end
        end
        if (b) hang("read");
    endtask
    task automatic wflag(input bit p);
        for (n = 0; (p ? fp : fa) !== 1'b1 && n < 1500; n++) @(posedge aclk);
        if (n == 1500) hang("flag");
    endtask
    task automatic restart(input [7:0] mode, input [9:0] a);
        wr(`OFS_TIMER_CONTROL, 0);
        wr(`OFS_FLAGS, 3);
        wr(`OFS_MODE_CONTROL, mode);
        wr(`OFS_COMPARE_A_LOW, a);
        wr(`OFS_COMPARE_A_HIGH, a >> 8);
    endtask
    function automatic logic exp_pin(input [1:0] f, input o, p);
        exp_pin = (f == 0 ? o : f == 1 ? 1'b0 : f == 2 ? 1'b1 : ~o) ^ p;
    endfunction

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        aclk = 0; aresetn = 0; clk_en = 1; awvalid = 0; wvalid = 0;
        bready = 0; arvalid = 0; rready = 0; cap = 0; awaddr = 0;
        araddr = 0; wdata = 0; err_count = 0; samples_checked = 0;
        v = $urandom(32'h1dc8_fc3f);
        repeat (4) @(posedge aclk);
        aresetn <= 1;
        for (k = 1; k < 7; k++) begin
            rd(6'(k * 4));
            check("reset_value", d, 0);
            check("read_resp", r, `RESP_OKAY);
        end
        rd(6'h1C);
        check("unmapped_read", r, `RESP_SLVERR);
        wr(6'h1C, $urandom);
        check("unmapped_write", r, `RESP_SLVERR);
        wr(`OFS_COUNT_LOW, $urandom);
        rd(`OFS_COUNT_LOW);
        check("count_read_only", d, 0);
        v = $urandom;
        wr(`OFS_COMPARE_A_LOW, v);
        wr(`OFS_COMPARE_A_HIGH, v >> 8);
        rd(`OFS_COMPARE_A_LOW);
        check("cmp_a_low", d, v & 32'h0000_00FF);
        rd(`OFS_COMPARE_A_HIGH);
        check("cmp_a_high", d, (v >> 8) & 32'h0000_0003);
        $display("Register map test done");
        for (k = 0; k < 4; k++) begin
            oc = ^$urandom;
            pol = ^$urandom;
            v = 20 + $urandom % 180;
            restart({2'b00, 2'(k), oc, pol, 2'b01}, v[9:0]);
            wr(`OFS_TIMER_CONTROL, 8);
            repeat (3) @(posedge aclk);
            check("pin_initial", pin, oc ^ pol);
            wflag(0);
            repeat (3) @(posedge aclk);
            check("pin_match", pin, exp_pin(k, oc, pol));
            check("p_flag_off", fp, 0);
            wr(`OFS_TIMER_CONTROL, 0);
            rd(`OFS_COUNT_LOW);
            lo = d;
            rd(`OFS_COUNT_HIGH);
            check("count_limit", {d[1:0], lo[7:0]} <= v, 1);
            rd(`OFS_COUNT_LOW);
            check("count_hold", d, lo);
        end
        $display("Compare output test done");
        restart(8'h00, 10'd64);
        wr(`OFS_TIMER_CONTROL, 9);
        wflag(1);
        check("p_period", n > 100 && n < 140, 1);
        check("a_flag_both", fa, 1);
        restart(8'h00, 10'd64);
        repeat (2) @(posedge aclk);
        check("flags_cleared", {fa, fp}, 0);
        $display("Flag test done");
        restart(8'h20, 10'd0);
        wr(`OFS_TIMER_CONTROL, 8);
        clk_en <= 0;
        repeat (5) @(posedge aclk);
        clk_en <= 1;
        repeat (1100) @(posedge aclk);
        check("a_flag_zero", fa, 0);
        check("pin_no_match", pin, 0);
        $display("Zero compare test done");
        restart(8'h70, 10'd0);
        wr(`OFS_TIMER_CONTROL, 8);
        repeat (100) @(posedge aclk);
        check("capture_off", fa, 0);
        restart(8'h40, 10'd0);
        wr(`OFS_TIMER_CONTROL, 8);
        wflag(0);
        check("capture_flag", fa, 1);
        $display("Capture test done");
        restart(8'hA8, 10'd32);
        wr(`OFS_TIMER_CONTROL, 9);
        repeat (10) @(posedge aclk);
        check("pwm_active", pin, 1);
        repeat (30) @(posedge aclk);
        check("pwm_idle", pin, 0);
        $display("PWM test done");
        restart(8'hE0, 10'd0);
        wr(`OFS_TIMER_CONTROL, 8);
        repeat (3) @(posedge aclk);
        check("pin_timer_mode", pin, 0);
        $display("Timer mode test done");
        test_done();
    end
endmodule
